// >>> inc/dmr_pkg.sv
package dmr_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_INFO    = 6'h00;
	localparam logic [5:0] ADDR_FEAT1   = 6'h01;
	localparam logic [5:0] ADDR_FEAT2   = 6'h02;
	localparam logic [5:0] ADDR_SETPT   = 6'h0D;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BL_LSB       = 0;
	localparam int WPRE_BIT     = 2;
	localparam int RPRE_BIT     = 3;
	localparam int WR_LSB       = 4;
	localparam int RPST_BIT     = 7;
	localparam int RL_LSB       = 0;
	localparam int WL_LSB       = 3;
	localparam int WLS_BIT      = 6;
	localparam int WLEV_BIT     = 7;
	localparam int SETPOINT_WRITE_SEL_BIT   = 6;
	localparam int SETPOINT_ACTIVE_SEL_BIT   = 7;
	localparam int ZQI_LSB      = 3;
	localparam int CA_TERM_STRAP_BIT     = 7;

	// ------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] BL_16     = 2'h0;
	localparam logic [1:0] BL_32     = 2'h1;
	localparam logic [1:0] BL_OTF    = 2'h2;
	localparam logic [1:0] ZQI_NONE  = 2'h0;
	localparam logic [1:0] ZQI_GOOD  = 2'h3;
	localparam logic [7:0] FEAT_RST  = 8'h00;
	localparam logic [7:0] BL32_ADD  = 8'h08;
	localparam logic [7:0] BEAT16    = 8'h10;
	localparam logic [7:0] BEAT32    = 8'h20;

	// ------------------------------------------------------------
	// Mode-register command carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] data;
	} dmr_cmd_t;

	// Decoded operating parameters of the active set point
	typedef struct packed {
		logic [1:0] burst_len_sel;
		logic       wr_pre_2ck;
		logic       rd_pre_toggle;
		logic       rd_trail_len;
		logic [7:0] write_recovery_cycles;
		logic [7:0] read_lat;
		logic [7:0] write_lat;
		logic [7:0] read_to_pre_cycles;
		logic       write_leveling;
	} dmr_op_t;

endpackage : dmr_pkg

// >>> src/dmr_regs.sv
module dmr_regs #(
	parameter int BEATS = 32
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire dmr_pkg::dmr_cmd_t cmd,
	input  wire logic              read_inversion_en,
	input  wire logic              ca_term_pad,
	input  wire logic              zq_init_done,
	input  wire logic [1:0]        zq_test_code,
	input  wire logic              rw_cmd,
	input  wire logic              rw_is_write,
	input  wire logic              rw_bl_bit,
	input  wire logic [4:0]        rw_col,
	input  wire logic [4:0]        beat_idx,
	output logic [7:0]             rd_data,
	output logic                   rd_valid,
	output dmr_pkg::dmr_op_t       op,
	output logic                   burst_is_32,
	output logic [4:0]             beat_col,
	output logic                   factory_trim,
	output logic                   zq_cal_ignore
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (BEATS != 32) begin : g_chk
		$error("dmr_regs supports a 32-beat column space only");
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] feat1 [2];
	logic [7:0] feat2 [2];
	logic       setpoint_write_sel;
	logic       setpoint_active_sel;
	logic [1:0] zq_selftest_result;
	logic       ca_term_strap;
	logic       strap_taken;
	logic       bl32_latched;
	logic [7:0] next_rd_data;

	// ------------------------------------------------------------
	// Write decode and active copies
	// ------------------------------------------------------------
	// Address 0 and unmapped addresses match no strobe, so a write there
	// leaves every register as it was
	wire logic wr_f1  = cmd.wr && cmd.addr == dmr_pkg::ADDR_FEAT1;
	wire logic wr_f2  = cmd.wr && cmd.addr == dmr_pkg::ADDR_FEAT2;
	wire logic wr_sp  = cmd.wr && cmd.addr == dmr_pkg::ADDR_SETPT;
	wire logic [7:0] act1 = feat1[setpoint_active_sel];
	wire logic [7:0] act2 = feat2[setpoint_active_sel];

	// only the write-selected copy takes the new value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			feat1[0] <= dmr_pkg::FEAT_RST;
			feat1[1] <= dmr_pkg::FEAT_RST;
			feat2[0] <= dmr_pkg::FEAT_RST;
			feat2[1] <= dmr_pkg::FEAT_RST;
		end else begin
			// Inactive copy may be rewritten freely while the active one runs
			if (wr_f1) begin
				feat1[setpoint_write_sel] <= cmd.data;
			end
			if (wr_f2) begin
				feat2[setpoint_write_sel] <= cmd.data;
			end
		end
	end

	// ------------------------------------------------------------
	// Set points and status
	// ------------------------------------------------------------
	// Set-point select bits; both move together on one write, so a switch
	// of the active copy never sees a half-updated select pair
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			setpoint_write_sel <= 1'b0;
			setpoint_active_sel <= 1'b0;
		end else if (wr_sp) begin
			setpoint_write_sel <= cmd.data[dmr_pkg::SETPOINT_WRITE_SEL_BIT];
			setpoint_active_sel <= cmd.data[dmr_pkg::SETPOINT_ACTIVE_SEL_BIT];
		end
	end

	// strap caught on first clock after reset release, not by reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken   <= 1'b0;
			ca_term_strap <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken   <= 1'b1;
			ca_term_strap <= ca_term_pad;
		end
	end

	// result refreshed when ZQ initialization completes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			zq_selftest_result <= dmr_pkg::ZQI_NONE;
		end else if (zq_init_done) begin
			// Later completions overwrite; the field shows the latest outcome
			zq_selftest_result <= zq_test_code;
		end
	end

	// codes 01 and 10 flag a possible assembly fault
	assign factory_trim  = zq_selftest_result != dmr_pkg::ZQI_NONE &&
	                       zq_selftest_result != dmr_pkg::ZQI_GOOD;
	assign zq_cal_ignore = factory_trim;

	// ------------------------------------------------------------
	// Latency tables
	// ------------------------------------------------------------
	// Each table is indexed by its three-bit code; entries run from code
	// 000 at the top to code 111 at the bottom, so a wrong row is easy to spot.
	// Lookups are pure decode, so they cost no cycle of latency.

	localparam logic [7:0] WR_TAB [8] = '{
		8'h06,
		8'h0A,
		8'h10,
		8'h14,
		8'h18,
		8'h1E,
		8'h22,
		8'h28
	};

	localparam logic [7:0] RL_TAB0 [8] = '{
		8'h06,
		8'h0A,
		8'h0E,
		8'h14,
		8'h18,
		8'h1C,
		8'h20,
		8'h24
	};

	localparam logic [7:0] RL_TAB1 [8] = '{
		8'h06,
		8'h0C,
		8'h10,
		8'h16,
		8'h1C,
		8'h20,
		8'h24,
		8'h28
	};

	// Read-to-precharge base, shared by both read latency tables
	localparam logic [7:0] RTP_TAB [8] = '{
		8'h08,
		8'h08,
		8'h08,
		8'h08,
		8'h0A,
		8'h0C,
		8'h0E,
		8'h10
	};

	localparam logic [7:0] WL_TABA [8] = '{
		8'h04,
		8'h06,
		8'h08,
		8'h0A,
		8'h0C,
		8'h0E,
		8'h10,
		8'h12
	};

	localparam logic [7:0] WL_TABB [8] = '{
		8'h04,
		8'h08,
		8'h0C,
		8'h12,
		8'h16,
		8'h1A,
		8'h1E,
		8'h22
	};

	wire logic [2:0] rl_code = act2[dmr_pkg::RL_LSB +: 3];
	wire logic [2:0] wl_code = act2[dmr_pkg::WL_LSB +: 3];
	wire logic [2:0] wr_code = act1[dmr_pkg::WR_LSB +: 3];
	wire logic [7:0] rtp_base = RTP_TAB[rl_code];

	// ------------------------------------------------------------
	// Decoded operating values
	// ------------------------------------------------------------
	// decoded values taken from the active copy only
	assign op.burst_len_sel         = act1[dmr_pkg::BL_LSB +: 2];
	assign op.wr_pre_2ck            = act1[dmr_pkg::WPRE_BIT];
	assign op.rd_pre_toggle         = act1[dmr_pkg::RPRE_BIT];
	assign op.rd_trail_len          = act1[dmr_pkg::RPST_BIT];
	assign op.write_recovery_cycles = WR_TAB[wr_code];
	// Inversion enable is a live level; the latency follows it at once
	assign op.read_lat              = read_inversion_en ? RL_TAB1[rl_code]
	                                                    : RL_TAB0[rl_code];
	assign op.write_lat             = act2[dmr_pkg::WLS_BIT] ? WL_TABB[wl_code]
	                                                         : WL_TABA[wl_code];
	// longer bursts delay the auto-close precharge
	assign op.read_to_pre_cycles    = bl32_latched ? 8'(rtp_base + dmr_pkg::BL32_ADD)
	                                               : rtp_base;
	assign op.write_leveling        = act2[dmr_pkg::WLEV_BIT];

	// ------------------------------------------------------------
	// Burst length and ordering
	// ------------------------------------------------------------
	// fixed 16, fixed 32, or per-command bit; reserved acts as 16
	wire logic cmd_bl32 = op.burst_len_sel == dmr_pkg::BL_32 ||
	                      (op.burst_len_sel == dmr_pkg::BL_OTF && rw_bl_bit);

	// Held per command so the precharge count matches the burst in flight
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bl32_latched <= 1'b0;
		end else if (rw_cmd) begin
			bl32_latched <= cmd_bl32;
		end
	end
	assign burst_is_32 = bl32_latched;

	// low column bits forced zero; writes also force bits 3:2 to zero
	wire logic [4:0] start_col = {rw_col[4:2] & {1'b1, {2{!rw_is_write}}}, 2'b00};
	logic [4:0] start_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 5'h00;
		end else if (rw_cmd) begin
			// Held for the whole burst; beat_idx alone walks the order
			start_q <= start_col;
		end
	end

	// wrap inside the current 16-beat half, then swap halves
	wire logic [3:0] low4 = 4'(start_q[3:0] + beat_idx[3:0]);
	wire logic       half = bl32_latched ? start_q[4] ^ beat_idx[4] : start_q[4];
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			beat_col <= 5'h00;
		end else begin
			// Registered so the column output carries no decode glitches
			beat_col <= {half, low4};
		end
	end

	// ------------------------------------------------------------
	// Mode-register read
	// ------------------------------------------------------------
	// info layout; latency read follows write-select copy
	always_comb begin
		next_rd_data = 8'h00;
		unique case (cmd.addr)
			dmr_pkg::ADDR_INFO: begin
				next_rd_data[dmr_pkg::CA_TERM_STRAP_BIT]     = ca_term_strap;
				next_rd_data[dmr_pkg::ZQI_LSB +: 2] = zq_selftest_result;
			end
			// Burst register is write-only; a read of it returns zero
			dmr_pkg::ADDR_FEAT1: next_rd_data = 8'h00;
			dmr_pkg::ADDR_FEAT2: next_rd_data = feat2[setpoint_write_sel];
			dmr_pkg::ADDR_SETPT: begin
				next_rd_data[dmr_pkg::SETPOINT_WRITE_SEL_BIT] = setpoint_write_sel;
				next_rd_data[dmr_pkg::SETPOINT_ACTIVE_SEL_BIT] = setpoint_active_sel;
			end
			default: next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= cmd.rd;
			// Data holds between reads so a late sampler still sees it
			if (cmd.rd) begin
				rd_data <= next_rd_data;
			end
		end
	end

endmodule : dmr_regs

// >>> bench/dmr_ctrl_model.sv
module dmr_ctrl_model (
	input  wire logic         sys_clk,
	input  wire logic [7:0]   rd_data,
	input  wire logic         rd_valid,
	output dmr_pkg::dmr_cmd_t cmd,
	output logic              rw_cmd,
	output logic              rw_is_write,
	output logic              rw_bl_bit,
	output logic [4:0]        rw_col
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet bus at time zero
	initial begin
		cmd = '0;
		{rw_cmd, rw_is_write, rw_bl_bit, rw_col} = '0;
	end
	// Mode-register command; idle lines flip so stale data never looks valid
	task automatic mr(input logic [1:0] k, input logic [5:0] a, input logic [7:0] v,
		output logic [7:0] q);
		@(posedge sys_clk);
		#1 cmd = {k, a, v};
		@(posedge sys_clk);
		#1 q = rd_valid ? rd_data : 8'hXX;
		cmd = {2'b00, ~a, ~v};
	endtask : mr
	// Read or write command; reads use a start column with nonzero low bits
	task automatic rwc(input logic w, input logic bl);
		@(posedge sys_clk);
		#1 {rw_cmd, rw_is_write, rw_bl_bit} = {1'b1, w, bl};
		rw_col = w ? 5'h10 : 5'h17;
		@(posedge sys_clk);
		#1 {rw_cmd, rw_bl_bit, rw_col} = {1'b0, ~bl, ~rw_col};
	endtask : rwc
endmodule : dmr_ctrl_model

// >>> bench/dmr_regs_checker.sv
module dmr_regs_checker #(parameter int BEATS = 32) (
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire dmr_pkg::dmr_cmd_t cmd,
	input wire logic              rw_cmd,
	input wire logic              rw_bl_bit,
	input wire logic              rd_valid,
	input wire dmr_pkg::dmr_op_t  op,
	input wire logic              burst_is_32
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (rd_valid == $past(cmd.rd))
		else $error("read answer not one cycle after request");
	op_hold_a: assert property (!cmd.wr |=> $stable({op.write_lat,
		op.write_recovery_cycles, op.write_leveling, op.burst_len_sel}))
		else $error("settings changed without a write");
	rlat_set_a: assert property (op.read_lat inside
		{8'h06,8'h0A,8'h0C,8'h0E,8'h10,8'h14,8'h16,8'h18,8'h1C,8'h20,8'h24,8'h28})
		else $error("read latency off table");
	wlat_set_a: assert property (op.write_lat inside
		{8'h04,8'h06,8'h08,8'h0A,8'h0C,8'h0E,8'h10,8'h12,8'h16,8'h1A,8'h1E,8'h22})
		else $error("write latency off table");
	wrec_set_a: assert property (op.write_recovery_cycles inside
		{8'h06,8'h0A,8'h10,8'h14,8'h18,8'h1E,8'h22,8'h28}) else $error("recovery off table");
	rtp_add_a: assert property ((op.read_to_pre_cycles - (burst_is_32 ? 8'h08 : 8'h00))
		inside {8'h08,8'h0A,8'h0C,8'h0E,8'h10}) else $error("read to close count wrong");
	bl_fixed_a: assert property (rw_cmd && op.burst_len_sel == dmr_pkg::BL_32
		|=> burst_is_32) else $error("fixed long burst not taken");
	bl_otf_a: assert property (rw_cmd && op.burst_len_sel == dmr_pkg::BL_OTF
		|=> burst_is_32 == $past(rw_bl_bit)) else $error("per-command burst bit ignored");
	rd_seen_c: cover property (rd_valid);
	long_seen_c: cover property (rw_cmd ##1 burst_is_32);
	lev_seen_c: cover property (op.write_leveling);
endmodule : dmr_regs_checker

bind dmr_regs dmr_regs_checker #(.BEATS(BEATS)) chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.cmd(cmd), .rw_cmd(rw_cmd), .rw_bl_bit(rw_bl_bit), .rd_valid(rd_valid), .op(op),
	.burst_is_32(burst_is_32));

// >>> bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n, read_inversion_en, ca_term_pad, zq_init_done, rd_valid, e;
	logic rw_cmd, rw_is_write, rw_bl_bit, burst_is_32, factory_trim, zq_cal_ignore;
	logic [1:0] zq_test_code;
	logic [4:0] rw_col, beat_idx, beat_col;
	logic [7:0] rd_data, d;
	dmr_pkg::dmr_cmd_t cmd;
	dmr_pkg::dmr_op_t op;
	int mismatches = 0;
	int check_count = 0;
	localparam logic [7:0] RLA [8] = '{8'h06,8'h0A,8'h0E,8'h14,8'h18,8'h1C,8'h20,8'h24};
	localparam logic [7:0] RLB [8] = '{8'h06,8'h0C,8'h10,8'h16,8'h1C,8'h20,8'h24,8'h28};
	localparam logic [7:0] WLA [8] = '{8'h04,8'h06,8'h08,8'h0A,8'h0C,8'h0E,8'h10,8'h12};
	localparam logic [7:0] WLB [8] = '{8'h04,8'h08,8'h0C,8'h12,8'h16,8'h1A,8'h1E,8'h22};
	localparam logic [7:0] WRT [8] = '{8'h06,8'h0A,8'h10,8'h14,8'h18,8'h1E,8'h22,8'h28};
	localparam logic [7:0] RTP [8] = '{8'h08,8'h08,8'h08,8'h08,8'h0A,8'h0C,8'h0E,8'h10};
	dmr_regs #(.BEATS(32)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd),
		.read_inversion_en(read_inversion_en), .ca_term_pad(ca_term_pad),
		.zq_init_done(zq_init_done), .zq_test_code(zq_test_code), .rw_cmd(rw_cmd),
		.rw_is_write(rw_is_write), .rw_bl_bit(rw_bl_bit), .rw_col(rw_col), .beat_idx(beat_idx),
		.rd_data(rd_data), .rd_valid(rd_valid), .op(op), .burst_is_32(burst_is_32),
		.beat_col(beat_col), .factory_trim(factory_trim), .zq_cal_ignore(zq_cal_ignore));
	dmr_ctrl_model ctrl (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd),
		.rw_cmd(rw_cmd), .rw_is_write(rw_is_write), .rw_bl_bit(rw_bl_bit), .rw_col(rw_col));
	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [7:0] s, input logic [7:0] x);
		check_count++;
		if (s !== x) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// strap is latched once, result only on calibration done
	task t_info();
		ctrl.mr(2'b01, dmr_pkg::ADDR_INFO, 8'h00, d);
		ca_term_pad = 1'b0;
		chk("info", d, 8'h80);
		for (int c = 1; c < 4; c++) begin
			zq_test_code = 2'(c);
			zq_init_done = 1'b1;
			@(posedge sys_clk);
			#1 zq_init_done = 1'b0;
			ctrl.mr(2'b01, dmr_pkg::ADDR_INFO, 8'h00, d);
			chk("zq", d, {3'b100, 2'(c), 3'b000});
			chk("trim", 8'({factory_trim, zq_cal_ignore}), (c == 3) ? 8'h00 : 8'h03);
		end
		ctrl.mr(2'b10, dmr_pkg::ADDR_INFO, 8'hFF, d);
		ctrl.mr(2'b01, dmr_pkg::ADDR_INFO, 8'h00, d);
		chk("info ro", d, 8'h98);
		ctrl.mr(2'b01, 6'h05, 8'h00, d);
		chk("unmapped", d, 8'h00);
	endtask : t_info
	// every latency code in both tables
	task t_lat();
		for (int i = 0; i < 16; i++) begin
			read_inversion_en = i[3];
			ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT1, 8'({3'(i), 4'h0}), d);
			ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT2, 8'({i[3], 3'(i), 3'(i)}), d);
			ctrl.mr(2'b01, dmr_pkg::ADDR_FEAT2, 8'h00, d);
			chk("feat2", d, 8'({i[3], 3'(i), 3'(i)}));
			chk("rl", op.read_lat, i[3] ? RLB[i[2:0]] : RLA[i[2:0]]);
			chk("wl", op.write_lat, i[3] ? WLB[i[2:0]] : WLA[i[2:0]]);
			chk("wr", op.write_recovery_cycles, WRT[i[2:0]]);
			chk("rtp16", op.read_to_pre_cycles, RTP[i[2:0]]);
		end
	endtask : t_lat
	// set-point copies; leveling holds while the bus is quiet
	task t_fsp();
		read_inversion_en = 1'b0;
		ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT2, 8'h38, d);
		ctrl.mr(2'b10, dmr_pkg::ADDR_SETPT, 8'h40, d);
		ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT2, 8'h88, d);
		chk("wl sp0", op.write_lat, 8'h12);
		chk("lev sp0", 8'(op.write_leveling), 8'h00);
		ctrl.mr(2'b01, dmr_pkg::ADDR_FEAT2, 8'h00, d);
		chk("rd sp1", d, 8'h88);
		ctrl.mr(2'b10, dmr_pkg::ADDR_SETPT, 8'hC0, d);
		#50;
		chk("wl sp1", op.write_lat, 8'h06);
		chk("lev on", 8'(op.write_leveling), 8'h01);
		ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT2, 8'h08, d);
		chk("lev off", 8'(op.write_leveling), 8'h00);
		ctrl.mr(2'b10, dmr_pkg::ADDR_SETPT, 8'h00, d);
		ctrl.mr(2'b01, dmr_pkg::ADDR_FEAT2, 8'h00, d);
		chk("rd sp0", d, 8'h38);
	endtask : t_fsp
	// each burst code with both command bits
	task t_bl();
		for (int i = 0; i < 8; i++) begin
			ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT1, {6'h23, 2'(i)}, d);
			ctrl.rwc(1'b0, i[2]);
			e = (i % 4 == 1) || (i % 4 == 2 && i > 3);
			chk("bl32", 8'(burst_is_32), 8'(e));
			chk("rtp", op.read_to_pre_cycles, e ? 8'h10 : 8'h08);
			chk("pre", 8'({op.rd_trail_len, op.rd_pre_toggle, op.wr_pre_2ck}), 8'h07);
		end
	endtask : t_bl
	// beat order of a long read, then a long write
	task t_beat();
		ctrl.mr(2'b10, dmr_pkg::ADDR_FEAT1, 8'h01, d);
		for (int w = 0; w < 2; w++) begin
			ctrl.rwc(w[0], 1'b0);
			for (int k = 0; k < 32; k++) begin
				beat_idx = 5'(k);
				#10;
				chk("beat", 8'(beat_col), 8'({~k[4], 2'(k / 4 + 1 - w), 2'(k)}));
			end
		end
	endtask : t_beat
	// Reset for six cycles, then the scenarios
	initial begin
		{rst_n, read_inversion_en, zq_init_done, zq_test_code, beat_idx} = '0;
		ca_term_pad = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		t_info();
		t_lat();
		t_fsp();
		t_bl();
		t_beat();
		print_verdict();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		print_verdict();
	end
endmodule : tb
